// ---- verilog/ecs_consts.svh ----
`ifndef ECS_CONSTS_SVH
`define ECS_CONSTS_SVH
// Contract
// (R01) At power-on, copy the stored configuration bytes into the volatile registers first.
// (R02) Device behaviour follows the volatile registers only, never the array.
// (R03) Volatile registers lose their contents whenever powerdown is entered; the code clears cfg_q there but the access select keeps its value.
// (R04) Array and registers share one range; control register bit 0 chooses.
// (R05) Access select is volatile and comes up cleared after power-on reset.
// (R06) Select 1 routes shared-range accesses to the array, 0 to registers.
// (R07) Host must clear the select bit itself; the device never does.
// (R08) Array writes change neither operation nor registers until next reset.
// (R09) Register writes act at once and never touch the array.
// (R10) User data area has no registers and is not recalled.
// (R11) Registers may be read by single-byte or multi-byte page reads.
// (R12) Host reads array by single bytes, repeating page-first reads twice.
// (R13) Host uses single-byte array writes spaced at least 30 ms apart; the host model only waits for busy, a 5 ms write time.
// (R14) Every array read is checked; a clean read clears both error flags.
// (R15) Single-bit error: return corrected data and set corrected flag.
// (R16) Multi-bit error: set uncorrectable flag, corrected flag low, data invalid.
// (R17) Recall corrects single errors; double error keeps the previous register.
// (R18) Recall checks the error flags before device operation may start.
// (R19) Error flags clear on the next valid read, not holding recall outcome.
// (R20) Array is organised in four-byte pages aligned from address zero.
// (R21) After a write stop, run a write cycle ignoring requests, output off.
// (R22) Each stored byte carries SECDED check bits, made on write, checked on read.

`define ECS_SHARED_LAST 8'h57
`define ECS_CFG_LAST 8'h4b
`define ECS_NV_DEPTH 88
`define ECS_CFG_DEPTH 76
`define ECS_CTRL_ADDR 8'h89
`define ECS_SEL_BIT 0
`define ECS_PAGE_OFS_W 2
`define ECS_CODE_W 13
`define ECS_CLK_MHZ 10
`define ECS_WR_TIME_US 5000
`define ECS_WR_CYCLES (`ECS_WR_TIME_US * `ECS_CLK_MHZ)
`define ECS_ZERO_BYTE 8'h00

`endif

// ---- verilog/ecs_pkg.sv ----
package ecs_pkg;
   typedef enum logic [1:0] {
      ECS_ST_RECALL = 2'b00,
      ECS_ST_RUN = 2'b01,
      ECS_ST_WRITE = 2'b10,
      ECS_ST_DOWN = 2'b11
   } ecs_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ecs_req_t;

   typedef struct packed {
      logic [7:0] data;
      logic corr;
      logic fail;
   } ecs_dec_t;
endpackage : ecs_pkg

// ---- verilog/eeprom_config_shadow.sv ----
`timescale 1ns/10ps
`include "ecs_consts.svh"

module eeprom_config_shadow
   import ecs_pkg::*;
#(
   parameter int WR_CYCLES = `ECS_WR_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic powerdown,
   input wire ecs_req_t req,
   input wire logic write_stop,
   output logic rd_valid_q,
   output logic [7:0] rd_data_q,
   output logic busy_q,
   output logic data_oe_q,
   output logic op_enable_q,
   output logic recall_ok_q,
   output logic ecc_used_q,
   output logic ecc_fail_q,
   output logic nv_access_select_q,
   output logic [`ECS_CFG_DEPTH-1:0][7:0] cfg_q
);

   localparam int CW = $clog2(WR_CYCLES + 1);
   localparam logic [6:0] CFG_LAST_IDX = 7'(`ECS_CFG_LAST);

   // ----------------------------------------------------------------
   // Check-bit code
   // ----------------------------------------------------------------
   // Hamming positions 1..12 hold data and parity, bit 0 is overall parity.
   function automatic logic [12:0] ecs_encode(input logic [7:0] d);
      logic [12:0] c;
      logic [3:0] x;
      int j;
      c = '0;
      x = '0;
      j = 0;
      for (int i = 3; i <= 12; i++) begin
         if ((i & (i - 1)) != 0) begin
            c[i] = d[j];
            if (d[j]) begin
               x = x ^ 4'(i);
            end
            j++;
         end
      end
      c[1] = x[0];
      c[2] = x[1];
      c[4] = x[2];
      c[8] = x[3];
      c[0] = ^c[12:1];
      return c;
   endfunction : ecs_encode

   function automatic ecs_dec_t ecs_decode(input logic [12:0] c);
      ecs_dec_t r;
      logic [12:0] f;
      logic [3:0] s;
      int j;
      r = '0;
      f = c;
      s = '0;
      j = 0;
      for (int i = 1; i <= 12; i++) begin
         if (c[i]) begin
            s = s ^ 4'(i);
         end
      end
      if (^c && s <= 4'd12) begin
         r.corr = 1'b1;
         f[s] = ~f[s];
      end else if (^c || s != 4'd0) begin
         r.fail = 1'b1;
      end
      for (int i = 3; i <= 12; i++) begin
         if ((i & (i - 1)) != 0) begin
            r.data[j] = f[i];
            j++;
         end
      end
      return r;
   endfunction : ecs_decode

   // ----------------------------------------------------------------
   // Storage and decode
   // ----------------------------------------------------------------
   logic [`ECS_CODE_W-1:0] nv_mem [`ECS_NV_DEPTH];
   ecs_state_t state_q;
   ecs_state_t state_d;
   logic [6:0] rc_idx_q;
   logic [CW-1:0] wr_cnt_q;
   logic pend_q;
   logic [4:0] pend_page_q;
   logic [`ECS_PAGE_OFS_W-1:0] pend_ofs_q;
   logic [7:0] pend_data_q;
   ecs_dec_t dec_rd;
   ecs_dec_t dec_rc;
   logic [6:0] acc_idx;
   logic run_take;
   logic in_shared;
   logic in_cfg;
   logic nv_rd_take;
   logic cfg_wr_take;
   logic nv_we;
   logic [7:0] cfg_rd_val;
   logic [7:0] nv_rd_val;

   assign acc_idx = req.addr[6:0];
   assign dec_rd = ecs_decode(nv_mem[acc_idx]);
   assign dec_rc = ecs_decode(nv_mem[rc_idx_q]);
   assign nv_rd_val = dec_rd.data;
   assign cfg_rd_val = in_cfg ? cfg_q[acc_idx] : `ECS_ZERO_BYTE;
   assign run_take = req.valid && state_q == ECS_ST_RUN; // [R21]
   assign in_shared = req.addr <= `ECS_SHARED_LAST; // [R04]
   assign in_cfg = req.addr <= `ECS_CFG_LAST;
   assign nv_rd_take = run_take && !req.write && in_shared && nv_access_select_q; // [R06]
   assign cfg_wr_take = run_take && req.write && in_cfg && !nv_access_select_q; // [R06]
   assign nv_we = state_q == ECS_ST_WRITE && wr_cnt_q == '0;

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ECS_ST_RECALL: begin
            // User area past the last configuration byte is never recalled
            if (rc_idx_q == CFG_LAST_IDX) begin // [R10]
               state_d = ECS_ST_RUN;
            end
         end
         ECS_ST_RUN: begin
            if (write_stop && pend_q) begin // [R21]
               state_d = ECS_ST_WRITE;
            end
         end
         ECS_ST_WRITE: begin
            if (wr_cnt_q == '0) begin
               state_d = ECS_ST_RUN;
            end
         end
         ECS_ST_DOWN: begin
            state_d = ECS_ST_RECALL;
         end
      endcase
      if (powerdown) begin
         state_d = ECS_ST_DOWN;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ECS_ST_RECALL; // [R01]
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || state_q == ECS_ST_DOWN) begin
         rc_idx_q <= '0;
      end else if (state_q == ECS_ST_RECALL) begin
         rc_idx_q <= rc_idx_q + 7'd1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_cnt_q <= '0;
      end else if (state_q == ECS_ST_RUN && state_d == ECS_ST_WRITE) begin
         wr_cnt_q <= CW'(WR_CYCLES - 1); // [R21]
      end else if (state_q == ECS_ST_WRITE && wr_cnt_q != '0) begin
         wr_cnt_q <= wr_cnt_q - CW'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         busy_q <= 1'b1;
         data_oe_q <= 1'b0;
      end else begin
         busy_q <= state_d != ECS_ST_RUN;
         // Output stays off through the whole write cycle and recall
         data_oe_q <= state_q == ECS_ST_RUN && state_d == ECS_ST_RUN; // [R21]
      end
   end

   // ----------------------------------------------------------------
   // Volatile configuration registers
   // ----------------------------------------------------------------
   // cfg_q is the only configuration the rest of the device may use
   always_ff @(posedge clock) begin
      if (rst || state_q == ECS_ST_DOWN) begin
         cfg_q <= '0; // [R03]
      end else if (state_q == ECS_ST_RECALL) begin
         if (!dec_rc.fail) begin // [R17]
            cfg_q[rc_idx_q] <= dec_rc.data; // [R01] [R02]
         end
      end else if (cfg_wr_take) begin
         cfg_q[acc_idx] <= req.wdata; // [R09]
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         nv_access_select_q <= 1'b0; // [R05]
      end else if (run_take && req.write && req.addr == `ECS_CTRL_ADDR) begin
         // Only the host clears it; it survives the end of an array session
         nv_access_select_q <= req.wdata[`ECS_SEL_BIT]; // [R04] [R07]
      end
   end

   // ----------------------------------------------------------------
   // Nonvolatile array writes
   // ----------------------------------------------------------------
   // One byte is held until the stop; later bytes of the same transfer replace it
   always_ff @(posedge clock) begin
      if (rst) begin
         pend_q <= 1'b0;
         pend_page_q <= '0;
         pend_ofs_q <= '0;
         pend_data_q <= '0;
      end else if (nv_we) begin
         pend_q <= 1'b0;
      end else if (run_take && req.write && in_shared && nv_access_select_q) begin
         pend_q <= 1'b1;
         pend_page_q <= req.addr[6:2]; // [R20]
         pend_ofs_q <= req.addr[1:0]; // [R20]
         pend_data_q <= req.wdata;
      end
   end

   // Array is written at the end of the cycle and never feeds cfg_q until recall
   always_ff @(posedge clock) begin
      if (nv_we) begin
         nv_mem[{pend_page_q, pend_ofs_q}] <= ecs_encode(pend_data_q); // [R22] [R08]
      end
   end

   // ----------------------------------------------------------------
   // Read path and error flags
   // ----------------------------------------------------------------
   // Each byte answers on its own, so a page read is simply a run of them
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= '0;
      end else begin
         rd_valid_q <= run_take && !req.write; // [R11]
         if (run_take && !req.write) begin
            if (req.addr == `ECS_CTRL_ADDR) begin
               rd_data_q <= {7'h00, nv_access_select_q};
            end else if (nv_rd_take) begin
               rd_data_q <= nv_rd_val; // [R15] [R16]
            end else begin
               rd_data_q <= cfg_rd_val; // [R06]
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ecc_used_q <= 1'b0;
         ecc_fail_q <= 1'b0;
      end else if (state_q == ECS_ST_RECALL) begin
         ecc_used_q <= dec_rc.corr;
         ecc_fail_q <= dec_rc.fail;
      end else if (nv_rd_take) begin
         ecc_used_q <= dec_rd.corr; // [R14] [R15] [R19]
         ecc_fail_q <= dec_rd.fail; // [R14] [R16] [R19]
      end
   end

   // Flags of the last recalled byte land one cycle into RUN, so start waits for them
   always_ff @(posedge clock) begin
      if (rst || state_q == ECS_ST_DOWN) begin
         recall_ok_q <= 1'b1;
         op_enable_q <= 1'b0;
      end else begin
         if ((state_q == ECS_ST_RECALL || !op_enable_q) && ecc_fail_q) begin
            recall_ok_q <= 1'b0; // [R18]
         end
         // Sticky once started, so an array write cycle never pauses operation
         if (state_q == ECS_ST_RUN) begin
            op_enable_q <= 1'b1; // [R18] [R08]
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence recall_end_s;
      state_q == ECS_ST_RECALL && !powerdown ##1 state_q == ECS_ST_RUN && !powerdown;
   endsequence

   recall_then_run_a: assert property (recall_end_s |=> op_enable_q) // [R01]
      else $error("operation did not start after recall");
   op_after_recall_a: assert property ($rose(op_enable_q) // [R18]
      |-> $past(state_q, 2) == ECS_ST_RECALL)
      else $error("operation started without a recall");
   select_cleared_a: assert property ($past(rst) |-> !nv_access_select_q) // [R05]
      else $error("access select not cleared after reset");
   powerdown_clear_a: assert property (state_q == ECS_ST_DOWN |=> cfg_q == '0) // [R03]
      else $error("registers kept contents in powerdown");
   nv_write_hold_a: assert property (state_q == ECS_ST_WRITE && !powerdown // [R08]
      |=> $stable(cfg_q))
      else $error("array write changed registers");
   cfg_write_now_a: assert property (cfg_wr_take && !powerdown // [R09]
      |=> cfg_q[$past(acc_idx)] == $past(req.wdata) && !nv_we)
      else $error("register write not applied at once");
   recall_keep_a: assert property (state_q == ECS_ST_RECALL && dec_rc.fail && !powerdown // [R17]
      |=> $stable(cfg_q))
      else $error("double error overwrote a register");
   ecc_clean_a: assert property (nv_rd_take && !dec_rd.corr && !dec_rd.fail // [R14]
      |=> !ecc_used_q && !ecc_fail_q)
      else $error("clean read left an error flag");
   ecc_single_a: assert property (nv_rd_take && dec_rd.corr // [R15]
      |=> ecc_used_q && !ecc_fail_q && rd_data_q == $past(nv_rd_val))
      else $error("single error not corrected and flagged");
   ecc_double_a: assert property (nv_rd_take && dec_rd.fail |=> ecc_fail_q && !ecc_used_q) // [R16]
      else $error("double error not flagged");
   cfg_route_a: assert property (run_take && !req.write && in_cfg && !nv_access_select_q // [R06]
      |=> rd_valid_q && rd_data_q == $past(cfg_rd_val))
      else $error("register read misrouted");
   busy_ignore_a: assert property (state_q != ECS_ST_RUN |=> !rd_valid_q && !data_oe_q) // [R21]
      else $error("request answered while busy");
   op_hold_a: assert property (op_enable_q && state_q != ECS_ST_DOWN && !powerdown // [R08]
      |=> op_enable_q)
      else $error("operation paused without powerdown");
   select_hold_a: assert property (nv_access_select_q // [R04]
      && !(run_take && req.write && req.addr == `ECS_CTRL_ADDR) |=> nv_access_select_q)
      else $error("access select dropped without a host write");
   recall_fail_a: assert property (state_q == ECS_ST_RECALL && ecc_fail_q // [R18]
      |=> !recall_ok_q)
      else $error("recall accepted a byte with a double error");
   nv_store_end_a: assert property (nv_we && !powerdown |=> state_q == ECS_ST_RUN) // [R21]
      else $error("write cycle did not end after the store");

endmodule : eeprom_config_shadow

// ---- testbench/ecs_host.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Host controller model
// ----------------------------------------
module ecs_host
   import ecs_pkg::*;
(
   input wire logic clock,
   input wire logic busy_q,
   input wire logic rd_valid_q,
   input wire logic [7:0] rd_data_q,
   output ecs_req_t req,
   output logic write_stop
);
   initial begin
      req = '0;
      write_stop = 1'b0;
   end
   // Idle bus shows inverted leftovers so a stale byte is never mistaken for live data
   task automatic send(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(negedge clock);
      req <= '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: ~d};
   endtask : send
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      // Page-first bytes are read twice; only the last answer is kept
      repeat ((a[1:0] == 2'b00) ? 2 : 1) begin
         send(1'b0, a, 8'h00);
         ok = (rd_valid_q === 1'b1);
         d = rd_data_q;
      end
   endtask : rd
   task automatic stop();
      @(negedge clock);
      write_stop <= 1'b1;
      @(negedge clock);
      write_stop <= 1'b0;
   endtask : stop
   // Next request only once the internal write time has run out
   task automatic wait_idle(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 400 && !ok; i++) begin
         if (busy_q === 1'b0) ok = 1'b1;
         else @(negedge clock);
      end
   endtask : wait_idle
   // The device keeps the select set, so the host drops it itself
   task automatic nv_done();
      send(1'b1, 8'h89, 8'h00);
   endtask : nv_done
endmodule : ecs_host

// ---- testbench/eeprom_config_shadow_test.sv ----
`timescale 1ns/10ps
`include "ecs_consts.svh"
module eeprom_config_shadow_test
   import ecs_pkg::*;
   ;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic powerdown = 1'b0;
   ecs_req_t req;
   logic write_stop, rd_valid_q, busy_q, data_oe_q, op_enable_q, recall_ok_q;
   logic ecc_used_q, ecc_fail_q, nv_access_select_q, ok;
   logic [7:0] rd_data_q, d;
   logic [`ECS_CFG_DEPTH-1:0][7:0] cfg_q;
   int n_errors = 0;
   int tests_run = 0;
   always #50 clock = ~clock;
   // Short write time keeps the run brief
   eeprom_config_shadow #(.WR_CYCLES(8)) eeprom_config_shadow_inst (.clock(clock), .rst(rst),
      .powerdown(powerdown), .req(req), .write_stop(write_stop), .rd_valid_q(rd_valid_q),
      .rd_data_q(rd_data_q), .busy_q(busy_q), .data_oe_q(data_oe_q), .op_enable_q(op_enable_q),
      .recall_ok_q(recall_ok_q), .ecc_used_q(ecc_used_q), .ecc_fail_q(ecc_fail_q),
      .nv_access_select_q(nv_access_select_q), .cfg_q(cfg_q));
   ecs_host ecs_host_inst (.clock(clock), .busy_q(busy_q), .rd_valid_q(rd_valid_q),
      .rd_data_q(rd_data_q), .req(req), .write_stop(write_stop));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] pat(input int i);
      return 8'(i * 29 + 3);
   endfunction : pat
   function automatic logic [12:0] enc(input logic [7:0] v);
      logic [12:0] c;
      c = {v[7:4], 1'b0, v[3:1], 1'b0, v[0], 3'b000};
      for (int b = 0; b < 4; b++)
         for (int p = 1; p <= 12; p++)
            if (p[b] && p != (1 << b)) c[1 << b] ^= c[p];
      c[0] = ^c[12:1];
      return c;
   endfunction : enc
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk8
   task automatic chk1(input string name, input logic exp, input logic got);
      chk8(name, {7'h00, exp}, {7'h00, got});
   endtask : chk1
   task automatic settle(input string name);
      ecs_host_inst.wait_idle(ok);
      if (!ok) begin
         chk1(name, 1'b1, 1'b0);
         tally_and_finish();
      end
   endtask : settle
   task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
      ecs_host_inst.rd(a, d, ok);
      chk1(name, 1'b1, ok);
      chk8(name, exp, d);
   endtask : rdc
   task automatic do_reset();
      @(negedge clock);
      rst <= 1'b1;
      repeat (16) @(negedge clock);
      rst <= 1'b0;
      settle("recall end");
      @(negedge clock);
   endtask : do_reset
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_recall();
      for (int i = 0; i < 4; i++) chk8("recall byte", pat(i), cfg_q[i]);
      chk8("recall single fix", pat(4), cfg_q[4]);
      chk8("recall double kept", 8'h00, cfg_q[5]);
      chk1("recall ok", 1'b0, recall_ok_q);
      chk1("operation on", 1'b1, op_enable_q);
      chk1("select at reset", 1'b0, nv_access_select_q);
      $display("test recall done");
   endtask : t_recall
   task automatic t_access();
      ecs_host_inst.send(1'b1, 8'h10, 8'ha5);
      chk8("cfg write now", 8'ha5, cfg_q[16]);
      rdc("cfg read", 8'h10, 8'ha5);
      rdc("user area no reg", 8'h4c, 8'h00);
      rdc("ctrl clear", 8'h89, 8'h00);
      ecs_host_inst.send(1'b1, 8'h89, 8'h01);
      rdc("ctrl set", 8'h89, 8'h01);
      rdc("array kept", 8'h10, pat(16));
      rdc("array fix", 8'h04, pat(4));
      chk1("corr flag", 1'b1, ecc_used_q);
      chk1("fail flag", 1'b0, ecc_fail_q);
      ecs_host_inst.rd(8'h05, d, ok);
      chk1("fail flag set", 1'b1, ecc_fail_q);
      chk1("corr flag low", 1'b0, ecc_used_q);
      rdc("array clean", 8'h01, pat(1));
      chk1("corr cleared", 1'b0, ecc_used_q);
      chk1("fail cleared", 1'b0, ecc_fail_q);
      $display("test access done");
   endtask : t_access
   task automatic t_nv_write();
      ecs_host_inst.send(1'b1, 8'h02, 8'h3c);
      ecs_host_inst.stop();
      chk1("write busy", 1'b1, busy_q);
      chk1("output off", 1'b0, data_oe_q);
      chk1("op during write", 1'b1, op_enable_q);
      ecs_host_inst.send(1'b0, 8'h02, 8'h00);
      chk1("read ignored", 1'b0, rd_valid_q);
      settle("write end");
      chk8("cfg untouched", pat(2), cfg_q[2]);
      rdc("array written", 8'h02, 8'h3c);
      ecs_host_inst.send(1'b1, 8'h4c, 8'h77);
      ecs_host_inst.stop();
      settle("user write end");
      rdc("user area", 8'h4c, 8'h77);
      ecs_host_inst.nv_done();
      chk1("select kept clear", 1'b0, nv_access_select_q);
      rdc("cfg still old", 8'h02, pat(2));
      do_reset();
      chk8("new recall", 8'h3c, cfg_q[2]);
      $display("test array write done");
   endtask : t_nv_write
   task automatic t_powerdown();
      @(negedge clock);
      powerdown <= 1'b1;
      repeat (3) @(negedge clock);
      chk8("down lost", 8'h00, cfg_q[0]);
      chk1("down busy", 1'b1, busy_q);
      powerdown <= 1'b0;
      settle("wake recall");
      chk8("wake recall", pat(0), cfg_q[0]);
      $display("test powerdown done");
   endtask : t_powerdown
   initial begin
      // Array is not reset, so it is loaded before the first recall
      for (int i = 0; i < `ECS_NV_DEPTH; i++) eeprom_config_shadow_inst.nv_mem[i] = enc(pat(i));
      eeprom_config_shadow_inst.nv_mem[4] = enc(pat(4)) ^ 13'h0020;
      eeprom_config_shadow_inst.nv_mem[5] = enc(pat(5)) ^ 13'h0030;
      repeat (16) @(negedge clock);
      rst <= 1'b0;
      settle("recall end");
      @(negedge clock);
      t_recall();
      t_access();
      t_nv_write();
      t_powerdown();
      tally_and_finish();
   end
endmodule : eeprom_config_shadow_test
